// file: design/dual_space_pkg.sv
// Package for the dual-space data memory paths: widths, boundary, access types.
// Assumes a single core clock and a synchronous active-low reset.
package dual_space_pkg;
   localparam int ADDR_W = 14;
   localparam int DATA_W = 16;
   localparam int MOD_W = 14;
   // Word index where the secondary space starts; fixed at build time
   localparam logic [13:0] SPACE_SPLIT = 14'h3000;
   localparam logic [13:0] ADDR_ZERO = 14'h0000;
   localparam logic [13:0] ADDR_ONE = 14'h0001;
   localparam logic [15:0] DATA_ZERO = 16'h0000;

   typedef enum logic [1:0] {
      AMODE_LINEAR = 2'h0,
      AMODE_MODULO = 2'h1,
      AMODE_BITREV = 2'h2
   } addr_mode_e;

   // One address request to an address generation unit
   typedef struct packed {
      logic valid;
      logic write;
      logic dual;
      addr_mode_e mode;
      logic [13:0] addr;
      logic [13:0] mod_start;
      logic [13:0] mod_end;
      logic [15:0] wdata;
   } agu_req_s;

   // One read answer
   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } rd_rsp_s;
endpackage

// file: design/dual_space_mem.sv
// Dual-space data RAM with primary and secondary address generators.
// Assumes the pipeline holds requests for one cycle and reads answers one cycle later.
// Function
// - Data memory is split into a primary and a secondary space that also form one linear range.
// - Each space has its own address generator and data path so, in the DSP variant, two words can be read at once.
// - The primary space serves every instruction and every addressing mode.
// - The primary space has separate read and write data buses.
// - The primary read bus carries all combined-space reads and the first dual operand.
// - In the DSP variant, dual-operand reads fetch a second operand in parallel through the secondary path.
// - Both spaces support modulo address generation.
// - Bit-reversed addressing applies only to primary-space writes.
// - The reduced variant has neither modulo nor bit-reversed addressing.
// - Every write addresses the combined space as a single range.
// - The space boundary is fixed per device and not changeable by software.
`timescale 1ns/1ps
module dual_space_mem #(
   parameter bit HAS_DSP = 1'b1,
   parameter int DEPTH = 16384
) (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire dual_space_pkg::agu_req_s pri_req_in,
   input wire dual_space_pkg::agu_req_s sec_req_in,
   output dual_space_pkg::rd_rsp_s pri_rsp_out,
   output dual_space_pkg::rd_rsp_s sec_rsp_out,
   output logic [13:0] pri_next_addr_out,
   output logic [13:0] sec_next_addr_out,
   output logic sec_err_out
);
   // one shared array
   // Not cleared by reset: a read before the first write returns unknown data
   logic [15:0] ram [DEPTH];
   logic [13:0] pri_addr;
   logic [13:0] sec_addr;
   logic [13:0] wr_addr;
   logic pri_rd;
   logic sec_rd;
   logic pri_wr;

   // Bit-reverse of a 14-bit word index
   function automatic logic [13:0] bit_rev(input logic [13:0] a);
      logic [13:0] r;
      r = dual_space_pkg::ADDR_ZERO;
      for (int i = 0; i < dual_space_pkg::ADDR_W; i++) begin
         r[i] = a[dual_space_pkg::ADDR_W - 1 - i];
      end
      return r;
   endfunction

   // Post-increment address with optional wrap; used by both generators
   // Increment only; a buffer that walks downward is not supported
   function automatic logic [13:0] step_addr(input dual_space_pkg::agu_req_s q,
                                             input logic allow_rev);
      logic [13:0] n;
      n = q.addr + dual_space_pkg::ADDR_ONE;
      if (HAS_DSP && q.mode == dual_space_pkg::AMODE_MODULO && q.addr == q.mod_end) begin
         n = q.mod_start;
      end
      if (HAS_DSP && allow_rev && q.write && q.mode == dual_space_pkg::AMODE_BITREV) begin
         n = bit_rev(bit_rev(q.addr) + dual_space_pkg::ADDR_ONE);
      end
      return n;
   endfunction

   assign pri_addr = pri_req_in.addr;
   assign sec_addr = sec_req_in.addr | dual_space_pkg::SPACE_SPLIT;
   assign wr_addr = pri_req_in.addr;
   assign pri_rd = pri_req_in.valid && !pri_req_in.write;
   assign sec_rd = sec_req_in.valid && !sec_req_in.write && sec_req_in.dual && HAS_DSP;
   assign pri_wr = pri_req_in.valid && pri_req_in.write;

   always_ff @(posedge ref_clk_in) begin
      if (pri_wr) begin
         ram[wr_addr] <= pri_req_in.wdata;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         pri_rsp_out <= '0;
      end else begin
         pri_rsp_out.valid <= pri_rd;
         pri_rsp_out.data <= pri_rd ? ram[pri_addr] : dual_space_pkg::DATA_ZERO;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         sec_rsp_out <= '0;
         sec_err_out <= 1'b0;
      end else begin
         sec_rsp_out.valid <= sec_rd;
         sec_rsp_out.data <= sec_rd ? ram[sec_addr] : dual_space_pkg::DATA_ZERO;
         sec_err_out <= sec_req_in.valid && (sec_req_in.write || !sec_rd);
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         pri_next_addr_out <= dual_space_pkg::ADDR_ZERO;
         sec_next_addr_out <= dual_space_pkg::ADDR_ZERO;
      end else begin
         if (pri_req_in.valid) begin
            pri_next_addr_out <= step_addr(pri_req_in, 1'b1);
         end
         if (sec_rd) begin
            sec_next_addr_out <= step_addr(sec_req_in, 1'b0);
         end
      end
   end

   // Every check samples the request at the taking edge and the answer one edge later
   // primary answer timing and next-address stepping
   a_pri_read_lat: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      pri_rd |=> pri_rsp_out.valid)
      else $error("primary read not answered");
   a_wr_no_rsp: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      pri_wr |=> !pri_rsp_out.valid)
      else $error("primary write answered");
   a_idle_quiet: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      !pri_rd |=> pri_rsp_out.data == dual_space_pkg::DATA_ZERO)
      else $error("primary data without read");
   a_pri_lin_step: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (pri_req_in.valid && pri_req_in.mode == dual_space_pkg::AMODE_LINEAR)
      |=> pri_next_addr_out == $past(pri_req_in.addr) + dual_space_pkg::ADDR_ONE)
      else $error("primary linear step wrong");
   a_pri_next_hold: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      !pri_req_in.valid |=> $stable(pri_next_addr_out))
      else $error("primary address moved while idle");

   a_sec_par_read: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (pri_rd && sec_rd) |=> (pri_rsp_out.valid && sec_rsp_out.valid))
      else $error("dual reads not parallel");
   a_sec_read_lat: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      sec_rd |=> (sec_rsp_out.valid && !sec_err_out))
      else $error("secondary read not answered");
   a_sec_idle_quiet: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      !sec_rd |=> (!sec_rsp_out.valid && sec_rsp_out.data == dual_space_pkg::DATA_ZERO))
      else $error("secondary data without read");
   a_sec_solo_err: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (sec_req_in.valid && !sec_req_in.dual) |=> sec_err_out)
      else $error("non-dual secondary read not refused");
   a_sec_no_write: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (sec_req_in.valid && sec_req_in.write) |=> (sec_err_out && !sec_rsp_out.valid))
      else $error("secondary write not refused");
   a_err_needs_req: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      !sec_req_in.valid |=> !sec_err_out)
      else $error("refusal without request");
   a_sec_lin_step: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (sec_rd && sec_req_in.mode == dual_space_pkg::AMODE_LINEAR)
      |=> sec_next_addr_out == $past(sec_req_in.addr) + dual_space_pkg::ADDR_ONE)
      else $error("secondary linear step wrong");
   a_sec_next_hold: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      !sec_rd |=> $stable(sec_next_addr_out))
      else $error("secondary address moved while idle");

   a_mod_wrap: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (HAS_DSP && pri_req_in.valid && pri_req_in.mode == dual_space_pkg::AMODE_MODULO
       && pri_req_in.addr == pri_req_in.mod_end)
      |=> pri_next_addr_out == $past(pri_req_in.mod_start))
      else $error("primary modulo wrap wrong");
   a_sec_mod_wrap: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (HAS_DSP && sec_rd && sec_req_in.mode == dual_space_pkg::AMODE_MODULO
       && sec_req_in.addr == sec_req_in.mod_end)
      |=> sec_next_addr_out == $past(sec_req_in.mod_start))
      else $error("secondary modulo wrap wrong");
   a_rev_low_step: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (HAS_DSP && pri_wr && pri_req_in.mode == dual_space_pkg::AMODE_BITREV
       && !pri_req_in.addr[dual_space_pkg::ADDR_W - 1])
      |=> pri_next_addr_out == {1'b1, $past(pri_req_in.addr[dual_space_pkg::ADDR_W - 2:0])})
      else $error("reversed step wrong");
   a_rev_top_step: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (HAS_DSP && pri_wr && pri_req_in.mode == dual_space_pkg::AMODE_BITREV
       && pri_req_in.addr[dual_space_pkg::ADDR_W - 1])
      |=> !pri_next_addr_out[dual_space_pkg::ADDR_W - 1])
      else $error("reversed carry wrong");
   a_no_sec_rev: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (sec_rd && sec_req_in.mode == dual_space_pkg::AMODE_BITREV)
      |=> sec_next_addr_out == $past(sec_req_in.addr) + dual_space_pkg::ADDR_ONE)
      else $error("secondary used bit reverse");
   a_rev_read_lin: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (pri_rd && pri_req_in.mode == dual_space_pkg::AMODE_BITREV)
      |=> pri_next_addr_out == $past(pri_req_in.addr) + dual_space_pkg::ADDR_ONE)
      else $error("read used bit reverse");
   a_reduced_lin: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (!HAS_DSP && pri_req_in.valid)
      |=> pri_next_addr_out == $past(pri_req_in.addr) + dual_space_pkg::ADDR_ONE)
      else $error("reduced variant not linear");
   a_lite_no_sec: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
      (!HAS_DSP && sec_req_in.valid)
      |=> (sec_err_out && !sec_rsp_out.valid))
      else $error("reduced variant served secondary");

   // Main scenarios
   c_dual_read: cover property (@(posedge ref_clk_in) disable iff (!rstn_in) pri_rd && sec_rd);
   c_write: cover property (@(posedge ref_clk_in) disable iff (!rstn_in) pri_wr);
   c_rev_write: cover property (@(posedge ref_clk_in) disable iff (!rstn_in)
      pri_wr && pri_req_in.mode == dual_space_pkg::AMODE_BITREV);
   c_mod_wrap: cover property (@(posedge ref_clk_in) disable iff (!rstn_in)
      pri_req_in.valid && pri_req_in.mode == dual_space_pkg::AMODE_MODULO
      && pri_req_in.addr == pri_req_in.mod_end);
   c_sec_refused: cover property (@(posedge ref_clk_in) disable iff (!rstn_in) sec_err_out);
endmodule // dual_space_mem

// file: verif/pipe_model.sv
// Pipeline side model: issues one primary and one secondary request per call.
// Assumes the block takes requests at a rising edge and answers one edge later.
`timescale 1ns/1ps
module pipe_model (
   input wire logic clk_in,
   output dual_space_pkg::agu_req_s pri_out,
   output dual_space_pkg::agu_req_s sec_out
);
   initial begin
      pri_out = '0;
      sec_out = '0;
   end
   task automatic issue(input dual_space_pkg::agu_req_s p, input dual_space_pkg::agu_req_s s);
      @(posedge clk_in);
      pri_out <= p;
      sec_out <= s;
      @(posedge clk_in);
      // Released fields invert so a stale value is never mistaken for a live one
      pri_out <= {1'b0, ~p[$bits(p)-2:0]};
      sec_out <= {1'b0, ~s[$bits(s)-2:0]};
      #1;
   endtask
endmodule // pipe_model

// file: verif/tb.sv
// Testbench for the dual-space data memory paths.
// Assumes the modulo window 0x0010 to 0x0013; the DSP and reduced variants run side by side.
`timescale 1ns/1ps
module tb;
   logic ref_clk_in = 1'b0;
   logic rstn_in = 1'b0;
   dual_space_pkg::agu_req_s pri_req, sec_req;
   dual_space_pkg::agu_req_s idle = '0;
   dual_space_pkg::rd_rsp_s pri_rsp, sec_rsp;
   logic [13:0] pri_next, sec_next;
   logic sec_err;
   dual_space_pkg::rd_rsp_s lite_pri_rsp, lite_sec_rsp;
   logic [13:0] lite_pri_next, lite_sec_next;
   logic lite_sec_err;
   int err_count = 0;
   int checked = 0;
   always #2.5 ref_clk_in = ~ref_clk_in;
   pipe_model i_pipe_model (.clk_in(ref_clk_in), .pri_out(pri_req), .sec_out(sec_req));
   dual_space_mem i_dual_space_mem (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
      .pri_req_in(pri_req), .sec_req_in(sec_req), .pri_rsp_out(pri_rsp),
      .sec_rsp_out(sec_rsp), .pri_next_addr_out(pri_next),
      .sec_next_addr_out(sec_next), .sec_err_out(sec_err));
   // Reduced variant on the same request stream
   dual_space_mem #(.HAS_DSP(1'b0)) i_dual_space_mem_lite (.ref_clk_in(ref_clk_in),
      .rstn_in(rstn_in), .pri_req_in(pri_req), .sec_req_in(sec_req),
      .pri_rsp_out(lite_pri_rsp), .sec_rsp_out(lite_sec_rsp),
      .pri_next_addr_out(lite_pri_next), .sec_next_addr_out(lite_sec_next),
      .sec_err_out(lite_sec_err));
   function automatic dual_space_pkg::agu_req_s rq(logic w, logic d,
         dual_space_pkg::addr_mode_e m, logic [13:0] a, logic [15:0] wd);
      rq = '{1'b1, w, d, m, a, 14'h0010, 14'h0013, wd};
   endfunction
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic t_dual();
      i_pipe_model.issue(rq(1, 0, dual_space_pkg::AMODE_LINEAR, 14'h3007, 16'h1234), idle);
      chk("write rsp", 16'h0000, {15'h0, pri_rsp.valid});
      i_pipe_model.issue(rq(1, 0, dual_space_pkg::AMODE_LINEAR, 14'h0007, 16'h5678), idle);
      chk("pri next", 16'h0008, {2'h0, pri_next});
      i_pipe_model.issue(rq(0, 1, dual_space_pkg::AMODE_LINEAR, 14'h0007, 16'h0000),
         rq(0, 1, dual_space_pkg::AMODE_LINEAR, 14'h0007, 16'h0000));
      chk("pri data", 16'h5678, pri_rsp.data);
      chk("sec data", 16'h1234, sec_rsp.data);
      chk("sec valid", 16'h0001, {15'h0, sec_rsp.valid});
      chk("sec next", 16'h0008, {2'h0, sec_next});
      chk("pri valid", 16'h0001, {15'h0, pri_rsp.valid});
      chk("dual err", 16'h0000, {15'h0, sec_err});
      i_pipe_model.issue(rq(0, 0, dual_space_pkg::AMODE_LINEAR, 14'h3007, 16'h0000), idle);
      chk("pri high data", 16'h1234, pri_rsp.data);
      $display("test dual done");
   endtask
   task automatic t_refuse();
      i_pipe_model.issue(idle, rq(1, 1, dual_space_pkg::AMODE_LINEAR, 14'h0007, 16'hFFFF));
      chk("sec err", 16'h0001, {15'h0, sec_err});
      chk("sec valid", 16'h0000, {15'h0, sec_rsp.valid});
      i_pipe_model.issue(idle, rq(0, 0, dual_space_pkg::AMODE_LINEAR, 14'h0007, 16'h0000));
      chk("sec err", 16'h0001, {15'h0, sec_err});
      i_pipe_model.issue(idle, rq(0, 1, dual_space_pkg::AMODE_LINEAR, 14'h0007, 16'h0000));
      chk("sec data", 16'h1234, sec_rsp.data);
      $display("test refuse done");
   endtask
   task automatic t_modes();
      i_pipe_model.issue(rq(0, 1, dual_space_pkg::AMODE_MODULO, 14'h0013, 16'h0000),
         rq(0, 1, dual_space_pkg::AMODE_MODULO, 14'h0013, 16'h0000));
      chk("pri wrap", 16'h0010, {2'h0, pri_next});
      chk("sec wrap", 16'h0010, {2'h0, sec_next});
      chk("lite pri next", 16'h0014, {2'h0, lite_pri_next});
      chk("lite pri valid", 16'h0001, {15'h0, lite_pri_rsp.valid});
      chk("lite sec err", 16'h0001, {15'h0, lite_sec_err});
      chk("lite sec next", 16'h0000, {2'h0, lite_sec_next});
      chk("lite sec valid", 16'h0000, {15'h0, lite_sec_rsp.valid});
      i_pipe_model.issue(rq(1, 0, dual_space_pkg::AMODE_BITREV, 14'h0000, 16'h0001), idle);
      chk("rev write", 16'h2000, {2'h0, pri_next});
      chk("lite rev write", 16'h0001, {2'h0, lite_pri_next});
      i_pipe_model.issue(rq(1, 0, dual_space_pkg::AMODE_BITREV, 14'h2000, 16'h0002), idle);
      chk("rev carry", 16'h1000, {2'h0, pri_next});
      i_pipe_model.issue(rq(0, 1, dual_space_pkg::AMODE_BITREV, 14'h0000, 16'h0000),
         rq(0, 1, dual_space_pkg::AMODE_BITREV, 14'h0000, 16'h0000));
      chk("rev read", 16'h0001, {2'h0, pri_next});
      chk("rev sec", 16'h0001, {2'h0, sec_next});
      $display("test modes done");
   endtask
   initial begin
      repeat (20) @(posedge ref_clk_in);
      rstn_in <= 1'b1;
      t_dual();
      t_refuse();
      t_modes();
      stop_test();
   end
endmodule // tb
